// ===== acsr_consts.vh
// Register indices, field positions and reset values of the setup bank
`ifndef ACSR_CONSTS_VH
`define ACSR_CONSTS_VH

// Register indices; byte address is four times the index
`define ACSR_IDX_SETUP0      6'h20
`define ACSR_IDX_SETUP1      6'h21
`define ACSR_IDX_SETUP2      6'h22
`define ACSR_IDX_SETUP3      6'h23
`define ACSR_IDX_STATUS      6'h24

// Field positions inside a setup word
`define ACSR_BIT_CODING      12
`define ACSR_BIT_POS_REFBUF  11
`define ACSR_BIT_NEG_REFBUF  10
`define ACSR_BIT_POS_INBUF   9
`define ACSR_BIT_NEG_INBUF   8
`define ACSR_BIT_OPEN_WIRE   7
`define ACSR_REFSEL_HI       5
`define ACSR_REFSEL_LO       4

// Reference select codes
`define ACSR_REF_EXTERNAL    2'h0
`define ACSR_REF_INTERNAL    2'h2
`define ACSR_REF_SUPPLY      2'h3

// Reset value and mask of writable bits
`define ACSR_SETUP_RESET     16'h1320
`define ACSR_SETUP_WMASK     16'h1fb0

// Status word field positions
`define ACSR_STAT_SETUP_HI   1
`define ACSR_STAT_SETUP_LO   0
`define ACSR_STAT_FAULT      2
`define ACSR_STAT_SEEN       3
`define ACSR_STAT_CFG_LO     16

`endif

// ===== acsr_setup_reg.v
// One 16-bit setup word with byte strobes and a writable-bit mask
`default_nettype none

module acsr_setup_reg #(
  parameter [15:0] RESET_VAL = 16'h1320,
  parameter [15:0] WMASK     = 16'h1fb0
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Write port
  input  wire        wr_en,
  input  wire [1:0]  wr_strb,
  input  wire [15:0] wr_data,
  // Stored value
  output wire [15:0] value
);

  reg [15:0] value_reg;
  reg [15:0] value_next;

  assign value = value_reg;

  //////////////////////////////////////////////////////////////////////////
  always @* begin
    value_next = value_reg;
    if (wr_en && wr_strb[0]) begin
      // Reserved bits never take written data
      value_next[7:0] = (value_reg[7:0] & ~WMASK[7:0]) |
                        (wr_data[7:0] & WMASK[7:0]);
    end
    if (wr_en && wr_strb[1]) begin
      value_next[15:8] = (value_reg[15:8] & ~WMASK[15:8]) |
                         (wr_data[15:8] & WMASK[15:8]);
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

endmodule

`default_nettype wire

// ===== acsr_setup_bank.v
// APB bank of four setup words and the per-conversion setup selection
//
// How it works
// - Bit 8 enables the negative analog input buffer; resets to one.
// - Bit 7 turns on open-wire burnout source and sink currents.
// - Bits 5:4 pick external, internal or supply-difference reference.
// - Reserved bits read zero, ignore writes; software writes them zero.
// - Setups one to three at 0x21-0x23 match setup zero, reset 0x1320.
// - Bit 12 selects unipolar (0) or bipolar offset-binary (1) coding.
// - Bits 11 and 10 enable positive and negative reference buffers.
// - Bit 9 enables the positive analog input buffer; resets to one.
`include "acsr_consts.vh"
`default_nettype none

module acsr_setup_bank #(
  parameter NUM_SETUPS = 4,
  parameter ADDR_W     = 8
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rstn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // Conversion sequencer
  input  wire              conv_start,
  input  wire [1:0]        conv_setup_sel,
  input  wire              int_ref_enabled,
  // Settings applied to the running conversion
  output wire              pos_input_buffer_en,
  output wire              neg_input_buffer_en,
  output wire              pos_ref_buffer_en,
  output wire              neg_ref_buffer_en,
  output wire              open_wire_current_en,
  output wire              output_coding_sel,
  output wire [1:0]        reference_select,
  output wire [1:0]        applied_setup,
  output wire              ref_config_fault
);

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  wire [ADDR_W-3:0] word_idx;
  wire              aligned;
  wire              hit_setup;
  wire              hit_status;
  wire              hit_any;
  wire [1:0]        setup_idx;
  wire              setup_phase;
  wire              access_phase;
  wire [5:0]        setup_base;

  // Setup words share the upper index bits of the first setup word
  assign setup_base   = `ACSR_IDX_SETUP0;

  assign word_idx     = paddr[ADDR_W-1:2];
  assign aligned      = (paddr[1:0] == 2'h0);
  assign setup_idx    = word_idx[1:0];
  assign hit_setup    = aligned &&
                        (word_idx[ADDR_W-3:2] ==
                         setup_base[5:2]) &&
                        ({30'h0, setup_idx} < NUM_SETUPS);
  assign hit_status   = aligned &&
                        (word_idx == `ACSR_IDX_STATUS);
  assign hit_any      = hit_setup || hit_status;
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  // Zero wait states: read data is staged in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_phase && !hit_any;

  //////////////////////////////////////////////////////////////////////////
  // Setup words

  wire [16*NUM_SETUPS-1:0] setup_flat;

  genvar g;
  generate
    for (g = 0; g < NUM_SETUPS; g = g + 1) begin : g_setup
      localparam [1:0] G_IDX = g;
      wire wr_hit;
      assign wr_hit = access_phase && pwrite && hit_setup &&
                      (setup_idx == G_IDX);
      acsr_setup_reg #(
        .RESET_VAL (`ACSR_SETUP_RESET),
        .WMASK     (`ACSR_SETUP_WMASK)
      ) u_setup (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (wr_hit),
        .wr_strb (pstrb[1:0]),
        .wr_data (pwdata[15:0]),
        .value   (setup_flat[16*g +: 16])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Applied configuration, latched at each conversion start

  reg  [15:0] applied_reg;
  reg  [15:0] applied_next;
  reg  [1:0]  applied_setup_reg;
  reg  [1:0]  applied_setup_next;
  reg         seen_reg;
  reg         fault_reg;
  wire        fault_next;
  wire [15:0] sel_word;

  assign sel_word = setup_flat[16*conv_setup_sel +: 16];

  // A write lands in the bank at once but reaches the analog front end
  // only at the next conversion start, so a running conversion is stable
  always @* begin
    applied_next       = applied_reg;
    applied_setup_next = applied_setup_reg;
    if (conv_start) begin
      applied_next       = sel_word & `ACSR_SETUP_WMASK;
      applied_setup_next = conv_setup_sel;
    end
  end

  // Internal code without the reference switched on gives no reference
  assign fault_next =
    (applied_reg[`ACSR_REFSEL_HI:`ACSR_REFSEL_LO] ==
     `ACSR_REF_INTERNAL) && !int_ref_enabled;

  always @(posedge clk) begin
    if (!rstn) begin
      applied_reg       <= `ACSR_SETUP_RESET;
      applied_setup_reg <= 2'h0;
      seen_reg          <= 1'b0;
      fault_reg         <= 1'b0;
    end else begin
      applied_reg       <= applied_next;
      applied_setup_reg <= applied_setup_next;
      seen_reg          <= seen_reg | conv_start;
      fault_reg         <= fault_next;
    end
  end

  assign output_coding_sel    = applied_reg[`ACSR_BIT_CODING];
  assign pos_ref_buffer_en    = applied_reg[`ACSR_BIT_POS_REFBUF];
  assign neg_ref_buffer_en    = applied_reg[`ACSR_BIT_NEG_REFBUF];
  assign pos_input_buffer_en  = applied_reg[`ACSR_BIT_POS_INBUF];
  assign neg_input_buffer_en  = applied_reg[`ACSR_BIT_NEG_INBUF];
  assign open_wire_current_en = applied_reg[`ACSR_BIT_OPEN_WIRE];
  assign reference_select     =
    applied_reg[`ACSR_REFSEL_HI:`ACSR_REFSEL_LO];
  assign applied_setup        = applied_setup_reg;
  assign ref_config_fault     = fault_reg;

  //////////////////////////////////////////////////////////////////////////
  // Read data

  reg  [31:0] prdata_reg;
  reg  [31:0] prdata_next;
  wire [31:0] status_word;
  wire [15:0] rd_setup;

  assign rd_setup    = setup_flat[16*setup_idx +: 16];
  assign status_word = {applied_reg, 12'h000, seen_reg, fault_reg,
                        applied_setup_reg};

  always @* begin
    prdata_next = prdata_reg;
    if (setup_phase) begin
      if (hit_setup) begin
        prdata_next = {16'h0000, rd_setup};
      end else if (hit_status) begin
        prdata_next = status_word;
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

endmodule

`default_nettype wire

// ===== acsr_setup_checker.sv
// Assertion checker for the setup configuration bank
`default_nettype none
module acsr_setup_checker #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  // Conversion
  input wire logic              conv_start,
  input wire logic [1:0]        conv_setup_sel,
  input wire logic              int_ref_enabled,
  input wire logic              pos_input_buffer_en,
  input wire logic              neg_input_buffer_en,
  input wire logic              pos_ref_buffer_en,
  input wire logic              neg_ref_buffer_en,
  input wire logic              open_wire_current_en,
  input wire logic              output_coding_sel,
  input wire logic [1:0]        reference_select,
  input wire logic [1:0]        applied_setup,
  input wire logic              ref_config_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Status is staged at the setup edge, so compare with the state there
  wire logic st = psel && !penable && !pwrite && paddr == 8'h90;
  wire logic su = psel && penable && !pwrite && paddr[7:4] == 4'h8;
  wire logic bad = reference_select == 2'h2 && !int_ref_enabled;
  wire logic [7:0] app = {output_coding_sel, pos_ref_buffer_en,
    neg_ref_buffer_en, pos_input_buffer_en, neg_input_buffer_en,
    open_wire_current_en, reference_select};
  a_rsvd_zero: assert property (su |-> prdata[31:13] == 19'h0 &&
    prdata[6] == 1'b0 && prdata[3:0] == 4'h0) else $error("reserved set");
  a_hold_applied: assert property (!conv_start |=>
    $stable(app) && $stable(applied_setup)) else $error("applied moved");
  a_sel_latched: assert property (conv_start |=>
    applied_setup == $past(conv_setup_sel)) else $error("wrong setup");
  a_stat_coding: assert property (st |=>
    prdata[28] == $past(output_coding_sel)) else $error("coding bit");
  a_stat_buffers: assert property (st |=>
    prdata[27:24] == $past(app[6:3])) else $error("buffer bits");
  a_stat_wire: assert property (st |=>
    prdata[23] == $past(open_wire_current_en)) else $error("wire bit");
  a_stat_refsel: assert property (st |=>
    prdata[21:20] == $past(reference_select)) else $error("ref field");
  a_ref_fault: assert property ($past(rstn) |->
    ref_config_fault == $past(bad)) else $error("fault flag");
endmodule

bind acsr_setup_bank acsr_setup_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .conv_start(conv_start), .conv_setup_sel(conv_setup_sel),
  .int_ref_enabled(int_ref_enabled),
  .pos_input_buffer_en(pos_input_buffer_en),
  .neg_input_buffer_en(neg_input_buffer_en),
  .pos_ref_buffer_en(pos_ref_buffer_en),
  .neg_ref_buffer_en(neg_ref_buffer_en),
  .open_wire_current_en(open_wire_current_en),
  .output_coding_sel(output_coding_sel),
  .reference_select(reference_select), .applied_setup(applied_setup),
  .ref_config_fault(ref_config_fault));
`default_nettype wire

// ===== tb_acsr_setup_bank.sv
// Self-checking bench for the setup configuration bank
`default_nettype none
module tb_acsr_setup_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        conv_start = 0, int_ref_enabled = 0, pready, pslverr;
  logic        pib, nib, prb, nrb, ow, cod, fault, e;
  logic [1:0]  conv_setup_sel = 0, refsel, asetup;
  logic [3:0]  pstrb = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] v [4] = '{16'hffff, 16'h1c80, 16'h0320, 16'h02b0};
  int          err_count = 0, num_checks = 0, cyc = 0;
  wire [7:0]   app = {cod, prb, nrb, pib, nib, ow, refsel};
  acsr_setup_bank dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_setup_sel(conv_setup_sel),
    .int_ref_enabled(int_ref_enabled), .pos_input_buffer_en(pib),
    .neg_input_buffer_en(nib), .pos_ref_buffer_en(prb),
    .neg_ref_buffer_en(nrb), .open_wire_current_en(ow),
    .output_coding_sel(cod), .reference_select(refsel),
    .applied_setup(asetup), .ref_config_fault(fault));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fld(input logic [15:0] d);
    return {d[12], d[11:7], d[5:4]};
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk("pready", 1'b1, pready);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic conv(input logic [1:0] s, input logic [15:0] d,
                      input logic f);
    @(posedge clk);
    conv_start <= 1;
    conv_setup_sel <= s;
    @(posedge clk);
    conv_start <= 0;
    @(posedge clk);
    #1;
    chk("applied", fld(d), app);
    chk("setup", s, asetup);
    chk("fault", f, fault);
  endtask
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(8'h80 + 4 * i), 0, 0);
      chk("reset", 32'h1320, r);
      apb(1, 8'(8'h80 + 4 * i), v[i], 4'h3);
      apb(0, 8'(8'h80 + 4 * i), 0, 0);
      chk("rdback", v[i] & 16'h1fb0, r);
    end
    // Internal reference left off first, so only setup 2 flags a fault
    for (int i = 0; i < 4; i++)
      conv(i[1:0], v[i], i == 2);
    @(posedge clk) int_ref_enabled <= 1;
    conv(2, v[2], 0);
    apb(1, 8'h88, 16'h0000, 4'h3);
    chk("held", fld(v[2]), app);
    conv(2, 16'h0000, 0);
    apb(1, 8'h84, 16'h0000, 4'h1);
    apb(0, 8'h84, 0, 0);
    chk("strobe", 32'h1c00, r);
    apb(0, 8'h90, 0, 0);
    chk("status", 2'h2, r[1:0]);
    apb(0, 8'h94, 0, 0);
    chk("unmapped", 1'b1, e);
    end_sim();
  end
endmodule
`default_nettype wire
